// *** swc_map.vh ***
`ifndef SWC_MAP_VH
`define SWC_MAP_VH
// register offsets
`define SWC_ACC_CTRL1 8'h00
`define SWC_ACC_CTRL4 8'h01
`define SWC_INT1_CFG 8'h02
`define SWC_INT1_THS 8'h03
`define SWC_INT1_DUR 8'h04
`define SWC_INT2_CFG 8'h05
`define SWC_INT2_THS 8'h06
`define SWC_INT2_DUR 8'h07
`define SWC_MAG_CFGA 8'h08
`define SWC_MAG_CFGB 8'h09
`define SWC_MAG_MODE 8'h0a
`define SWC_IRQ_STAT 8'h0b
`define SWC_IRQ_MASK 8'h0c
`define SWC_STATE 8'h0d
`define SWC_ACC_OUT 8'h10
`define SWC_MAG_OUT 8'h18
`define SWC_TRIM_SENS 8'h1e
`define SWC_TRIM_OFF 8'h1f
// field positions
`define SWC_LP_BIT 0
`define SWC_WAKE_BIT 1
`define SWC_SELFTEST_BIT 0
`define SWC_FF_BIT 3
`define SWC_EV_ADRDY 0
`define SWC_EV_MDRDY 1
`define SWC_EV_INT1 2
`define SWC_EV_INT2 3
`define SWC_EV_WAKE 4
`define SWC_EV_TRIM 5
// encodings
`define SWC_BIAS_NORMAL 2'b00
`define SWC_BIAS_POS 2'b01
`define SWC_MODE_CONT 2'b00
`define SWC_MODE_SINGLE 2'b01
`define SWC_MODE_IDLE 2'b11
// reset values
`define SWC_CTRL1_RST 8'h00
`define SWC_CTRL4_RST 8'h00
`define SWC_CFG_RST 8'h00
`define SWC_MODE_RST 8'h03
`define SWC_CFGB_RST 8'h20
// nvm trim locations
`define SWC_NVM_SENS 8'h00
`define SWC_NVM_OFF 8'h01
// timing: set pulse width in ns, clock period in ns
`define SWC_SET_NS 1000
`define SWC_CLK_NS 50
`endif

// *** swc_accel_event.v ***
`timescale 1ns/1ns
`include "swc_map.vh"
// inertial event detector for one interrupt output
module swc_accel_event #(
   parameter W = 16
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // acceleration samples
   input wire sample_valid,
   input wire signed [W-1:0] ax,
   input wire signed [W-1:0] ay,
   input wire signed [W-1:0] az,
   // configuration
   input wire [7:0] cfg,
   input wire [7:0] ths,
   input wire [7:0] dur,
   // results
   output reg int_reg,
   output reg rise_reg
);
   // magnitude of one axis, unsigned; the most negative value maps to itself
   function [W-1:0] mag_abs;
      input [W-1:0] v;
      begin
         mag_abs = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
      end
   endfunction

   wire [W-1:0] lim = {1'b0, ths[6:0], {(W-8){1'b0}}};
   wire [2:0] above;
   wire [2:0] en = cfg[2:0];
   reg hit;
   reg [7:0] cnt_reg;

   assign above[0] = mag_abs(ax) > lim;
   assign above[1] = mag_abs(ay) > lim;
   assign above[2] = mag_abs(az) > lim;

   // free-fall: every enabled axis low; wakeup: any enabled axis high
   always @* begin
      if (cfg[`SWC_FF_BIT]) begin
         hit = (en != 3'h0) && ((above & en) == 3'h0);
      end else begin
         hit = (above & en) != 3'h0;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         int_reg <= 1'b0;
         rise_reg <= 1'b0;
      end else begin
         rise_reg <= 1'b0;
         if (sample_valid) begin
            if (!hit) begin
               cnt_reg <= 8'h00;
               int_reg <= 1'b0;
            end else if (cnt_reg >= dur) begin
               int_reg <= 1'b1;
               rise_reg <= ~int_reg;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end
endmodule

// *** swc_top.v ***
`timescale 1ns/1ns
`include "swc_map.vh"
// accelerometer self-test, wake and magnetometer self-test control
module swc_top #(
   parameter W = 16
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // trim store
   output reg nvm_rd,
   output reg [7:0] nvm_addr,
   input wire [7:0] nvm_data,
   // accelerometer front end
   input wire acc_sample_valid,
   input wire signed [W-1:0] acc_raw_x,
   input wire signed [W-1:0] acc_raw_y,
   input wire signed [W-1:0] acc_raw_z,
   output reg acc_test_force,
   output reg acc_odr_high,
   // magnetometer front end
   input wire mag_core_pwr,
   output reg mag_acq_start,
   output reg mag_set_pulse,
   output reg mag_strap_en,
   input wire mag_acq_valid,
   input wire signed [W-1:0] mag_raw_x,
   input wire signed [W-1:0] mag_raw_y,
   input wire signed [W-1:0] mag_raw_z,
   // status pins
   output reg drdy_acc,
   output reg drdy_mag,
   output wire int1,
   output wire int2,
   output reg irq
);
   ////////////////////////////////////////////////////////////////////
   // constants
   localparam integer SET_CYC_I = (`SWC_SET_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
   localparam [7:0] SET_CYC = SET_CYC_I[7:0];
   // magnetometer sequence states
   localparam [1:0] MS_IDLE = 2'd0;
   localparam [1:0] MS_SET = 2'd1;
   localparam [1:0] MS_ACQ1 = 2'd2;
   localparam [1:0] MS_ACQ2 = 2'd3;

   ////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] ctrl1_reg; // low power and wake enable
   reg [7:0] accel_control_four; // self-test bit and scale
   reg [7:0] i1cfg_reg, i1ths_reg, i1dur_reg;
   reg [7:0] i2cfg_reg, i2ths_reg, i2dur_reg;
   reg [7:0] cfga_reg; // bias bits in the low two bits
   reg [7:0] cfgb_reg; // mag_gain_select in bits 7:5
   reg [7:0] mode_reg;
   reg [5:0] stat_reg, mask_reg;
   reg [7:0] accel_sensitivity_trim, accel_zero_offset_trim;
   reg trim_done_reg;
   reg [1:0] trim_step_reg;
   reg awake_reg; // set by wake event
   reg [W-1:0] acc_x_reg, acc_y_reg, acc_z_reg;
   reg [W-1:0] mag_x_reg, mag_y_reg, mag_z_reg;
   reg [W-1:0] first_x_reg, first_y_reg, first_z_reg;
   reg [W-1:0] res_x_reg, res_y_reg, res_z_reg;
   reg pend_reg; // result waiting for a cycle with no host read
   reg [1:0] ms_reg;
   reg [7:0] set_cnt_reg;
   reg pwr_s1_reg, pwr_s2_reg; // core supply synchroniser
   reg single_done; // fsm finished a single conversion
   reg mag_new; // result stored this cycle

   wire [1:0] mag_bias_cfg = cfga_reg[1:0];
   wire mag_bias_cfg_hi = mag_bias_cfg[1];
   wire mag_bias_cfg_lo = mag_bias_cfg[0];
   wire [2:0] mag_gain_select = cfgb_reg[7:5];
   wire selftest_on = {mag_bias_cfg_hi, mag_bias_cfg_lo} == `SWC_BIAS_POS;
   wire i1_lvl, i2_lvl, i1_rise, i2_rise;
   wire [5:0] ev;
   wire acc_new = acc_sample_valid & trim_done_reg;
   wire wake_ev = (i1_rise | i2_rise) & ctrl1_reg[`SWC_LP_BIT] & ctrl1_reg[`SWC_WAKE_BIT] & ~awake_reg;
   wire rd_acc_z = reg_rd && reg_addr == (`SWC_ACC_OUT + 8'h05);
   wire rd_mag_z = reg_rd && reg_addr == (`SWC_MAG_OUT + 8'h05);

   // offset trim, then full-scale shift selected in the control register
   function [W-1:0] acc_scale;
      input [W-1:0] raw;
      input [7:0] off;
      input [1:0] fs;
      reg [W-1:0] t;
      begin
         t = raw - {{(W-8){off[7]}}, off};
         acc_scale = $signed(t) >>> fs;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // inertial interrupt detectors
   // detectors run on every sample taken after the trim download
   swc_accel_event #(.W(W)) u_ev1 (
      .clk(clk),
      .rst_n(rst_n),
      .sample_valid(acc_new),
      .ax(acc_raw_x),
      .ay(acc_raw_y),
      .az(acc_raw_z),
      .cfg(i1cfg_reg),
      .ths(i1ths_reg),
      .dur(i1dur_reg),
      .int_reg(i1_lvl),
      .rise_reg(i1_rise)
   );
   swc_accel_event #(.W(W)) u_ev2 (
      .clk(clk),
      .rst_n(rst_n),
      .sample_valid(acc_new),
      .ax(acc_raw_x),
      .ay(acc_raw_y),
      .az(acc_raw_z),
      .cfg(i2cfg_reg),
      .ths(i2ths_reg),
      .dur(i2dur_reg),
      .int_reg(i2_lvl),
      .rise_reg(i2_rise)
   );
   assign int1 = i1_lvl;
   assign int2 = i2_lvl;

   ////////////////////////////////////////////////////////////////////
   // host register writes
   assign ev = {trim_step_reg == 2'd1 ? 1'b0 : (trim_step_reg == 2'd2), wake_ev, i2_rise, i1_rise, mag_new, acc_new};
   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl1_reg <= `SWC_CTRL1_RST;
         accel_control_four <= `SWC_CTRL4_RST;
         i1cfg_reg <= `SWC_CFG_RST;
         i1ths_reg <= `SWC_CFG_RST;
         i1dur_reg <= `SWC_CFG_RST;
         i2cfg_reg <= `SWC_CFG_RST;
         i2ths_reg <= `SWC_CFG_RST;
         i2dur_reg <= `SWC_CFG_RST;
         cfga_reg <= `SWC_CFG_RST;
         cfgb_reg <= `SWC_CFGB_RST;
         mode_reg <= `SWC_MODE_RST;
         mask_reg <= 6'h00;
         stat_reg <= 6'h00;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `SWC_ACC_CTRL1: ctrl1_reg <= reg_wdata;
               `SWC_ACC_CTRL4: accel_control_four <= reg_wdata;
               `SWC_INT1_CFG: i1cfg_reg <= reg_wdata;
               `SWC_INT1_THS: i1ths_reg <= reg_wdata;
               `SWC_INT1_DUR: i1dur_reg <= reg_wdata;
               `SWC_INT2_CFG: i2cfg_reg <= reg_wdata;
               `SWC_INT2_THS: i2ths_reg <= reg_wdata;
               `SWC_INT2_DUR: i2dur_reg <= reg_wdata;
               `SWC_MAG_CFGA: cfga_reg <= reg_wdata;
               `SWC_MAG_CFGB: cfgb_reg <= reg_wdata;
               `SWC_IRQ_MASK: mask_reg <= reg_wdata[5:0];
               default: ;
            endcase
         end
         // single conversion falls back to idle; a host write wins
         if (reg_wr && reg_addr == `SWC_MAG_MODE) begin
            mode_reg <= reg_wdata;
         end else if (single_done) begin
            mode_reg <= {6'h00, `SWC_MODE_IDLE};
         end
         // sticky events, write one to clear, a new event wins
         if (reg_wr && reg_addr == `SWC_IRQ_STAT) begin
            stat_reg <= (stat_reg & ~reg_wdata[5:0]) | ev;
         end else begin
            stat_reg <= stat_reg | ev;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // host register reads, data one cycle after the strobe
   // access works with the core supply off
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SWC_ACC_CTRL1: reg_rdata <= ctrl1_reg;
            `SWC_ACC_CTRL4: reg_rdata <= accel_control_four;
            `SWC_INT1_CFG: reg_rdata <= i1cfg_reg;
            `SWC_INT1_THS: reg_rdata <= i1ths_reg;
            `SWC_INT1_DUR: reg_rdata <= i1dur_reg;
            `SWC_INT2_CFG: reg_rdata <= i2cfg_reg;
            `SWC_INT2_THS: reg_rdata <= i2ths_reg;
            `SWC_INT2_DUR: reg_rdata <= i2dur_reg;
            `SWC_MAG_CFGA: reg_rdata <= cfga_reg;
            `SWC_MAG_CFGB: reg_rdata <= {mag_gain_select, cfgb_reg[4:0]};
            `SWC_MAG_MODE: reg_rdata <= mode_reg;
            `SWC_IRQ_STAT: reg_rdata <= {2'b00, stat_reg};
            `SWC_IRQ_MASK: reg_rdata <= {2'b00, mask_reg};
            `SWC_STATE: reg_rdata <= {2'b00, ms_reg, pwr_s2_reg, trim_done_reg, acc_odr_high, awake_reg};
            `SWC_ACC_OUT: reg_rdata <= acc_x_reg[7:0];
            8'h11: reg_rdata <= acc_x_reg[15:8];
            8'h12: reg_rdata <= acc_y_reg[7:0];
            8'h13: reg_rdata <= acc_y_reg[15:8];
            8'h14: reg_rdata <= acc_z_reg[7:0];
            8'h15: reg_rdata <= acc_z_reg[15:8];
            `SWC_MAG_OUT: reg_rdata <= mag_x_reg[7:0];
            8'h19: reg_rdata <= mag_x_reg[15:8];
            8'h1a: reg_rdata <= mag_y_reg[7:0];
            8'h1b: reg_rdata <= mag_y_reg[15:8];
            8'h1c: reg_rdata <= mag_z_reg[7:0];
            8'h1d: reg_rdata <= mag_z_reg[15:8];
            `SWC_TRIM_SENS: reg_rdata <= accel_sensitivity_trim;
            `SWC_TRIM_OFF: reg_rdata <= accel_zero_offset_trim;
            // unmapped addresses read zero
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // trim download after reset
   // two reads from the trim store before sampling starts
   always @(posedge clk) begin
      if (!rst_n) begin
         trim_step_reg <= 2'd0;
         trim_done_reg <= 1'b0;
         nvm_rd <= 1'b0;
         nvm_addr <= 8'h00;
         accel_sensitivity_trim <= 8'h00;
         accel_zero_offset_trim <= 8'h00;
      end else begin
         nvm_rd <= 1'b0;
         case (trim_step_reg)
            2'd0: begin
               nvm_rd <= 1'b1;
               nvm_addr <= `SWC_NVM_SENS;
               trim_step_reg <= 2'd1;
            end
            2'd1: begin
               accel_sensitivity_trim <= nvm_data;
               nvm_rd <= 1'b1;
               nvm_addr <= `SWC_NVM_OFF;
               trim_step_reg <= 2'd2;
            end
            2'd2: begin
               accel_zero_offset_trim <= nvm_data;
               trim_done_reg <= 1'b1;
               trim_step_reg <= 2'd3;
            end
            default: trim_step_reg <= 2'd3;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // accelerometer data, self-test drive and wake
   always @(posedge clk) begin
      if (!rst_n) begin
         acc_x_reg <= {W{1'b0}};
         acc_y_reg <= {W{1'b0}};
         acc_z_reg <= {W{1'b0}};
         acc_test_force <= 1'b0;
         acc_odr_high <= 1'b1;
         awake_reg <= 1'b0;
         drdy_acc <= 1'b0;
         irq <= 1'b0;
      end else begin
         // actuation follows the self-test bit only
         acc_test_force <= accel_control_four[`SWC_SELFTEST_BIT];
         // output scaled by selected full scale
         if (acc_new) begin
            acc_x_reg <= acc_scale(acc_raw_x, accel_zero_offset_trim, accel_control_four[5:4]);
            acc_y_reg <= acc_scale(acc_raw_y, accel_zero_offset_trim, accel_control_four[5:4]);
            acc_z_reg <= acc_scale(acc_raw_z, accel_zero_offset_trim, accel_control_four[5:4]);
         end
         // wake event raises rate until control is rewritten
         if (wake_ev) begin
            awake_reg <= 1'b1;
         end else if (reg_wr && reg_addr == `SWC_ACC_CTRL1) begin
            awake_reg <= 1'b0;
         end
         acc_odr_high <= ~ctrl1_reg[`SWC_LP_BIT] | awake_reg | wake_ev;
         // fresh set flag; cleared by reading z high, new set wins
         if (acc_new) begin
            drdy_acc <= 1'b1;
         end else if (rd_acc_z) begin
            drdy_acc <= 1'b0;
         end
         irq <= |((stat_reg | ev) & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // magnetometer conversion sequence
   always @(posedge clk) begin
      if (!rst_n) begin
         pwr_s1_reg <= 1'b0;
         pwr_s2_reg <= 1'b0;
         ms_reg <= MS_IDLE;
         set_cnt_reg <= 8'h00;
         mag_acq_start <= 1'b0;
         mag_set_pulse <= 1'b0;
         mag_strap_en <= 1'b0;
         first_x_reg <= {W{1'b0}};
         first_y_reg <= {W{1'b0}};
         first_z_reg <= {W{1'b0}};
         res_x_reg <= {W{1'b0}};
         res_y_reg <= {W{1'b0}};
         res_z_reg <= {W{1'b0}};
         pend_reg <= 1'b0;
         single_done <= 1'b0;
      end else begin
         pwr_s1_reg <= mag_core_pwr;
         pwr_s2_reg <= pwr_s1_reg;
         mag_acq_start <= 1'b0;
         single_done <= 1'b0;
         if (mag_new) begin
            pend_reg <= 1'b0;
         end
         if (!pwr_s2_reg) begin
            ms_reg <= MS_IDLE;
            mag_set_pulse <= 1'b0;
            mag_strap_en <= 1'b0;
         end else begin
            case (ms_reg)
               MS_IDLE: begin
                  if (trim_done_reg && !pend_reg &&
                      (mode_reg[1:0] == `SWC_MODE_CONT || mode_reg[1:0] == `SWC_MODE_SINGLE)) begin
                     mag_set_pulse <= 1'b1;
                     set_cnt_reg <= SET_CYC;
                     ms_reg <= MS_SET;
                  end
               end
               MS_SET: begin
                  if (set_cnt_reg == 8'h01) begin
                     mag_set_pulse <= 1'b0;
                     mag_acq_start <= 1'b1;
                     ms_reg <= MS_ACQ1;
                  end
                  set_cnt_reg <= set_cnt_reg - 8'h01;
               end
               MS_ACQ1: begin
                  if (mag_acq_valid) begin
                     if (selftest_on && mode_reg[1:0] == `SWC_MODE_SINGLE) begin
                        // keep first, start biased second acquisition
                        first_x_reg <= mag_raw_x;
                        first_y_reg <= mag_raw_y;
                        first_z_reg <= mag_raw_z;
                        mag_strap_en <= 1'b1;
                        mag_acq_start <= 1'b1;
                        ms_reg <= MS_ACQ2;
                     end else begin
                        res_x_reg <= mag_raw_x;
                        res_y_reg <= mag_raw_y;
                        res_z_reg <= mag_raw_z;
                        pend_reg <= 1'b1;
                        single_done <= mode_reg[1:0] == `SWC_MODE_SINGLE;
                        ms_reg <= MS_IDLE;
                     end
                  end
               end
               MS_ACQ2: begin
                  if (mag_acq_valid) begin
                     // net value is second minus first
                     res_x_reg <= mag_raw_x - first_x_reg;
                     res_y_reg <= mag_raw_y - first_y_reg;
                     res_z_reg <= mag_raw_z - first_z_reg;
                     pend_reg <= 1'b1;
                     mag_strap_en <= 1'b0;
                     // back to idle after the pair
                     single_done <= 1'b1;
                     ms_reg <= MS_IDLE;
                  end
               end
               default: ms_reg <= MS_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // magnetic data registers
   // results wait while the host is reading
   always @* begin
      mag_new = pend_reg & ~reg_rd;
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         mag_x_reg <= {W{1'b0}};
         mag_y_reg <= {W{1'b0}};
         mag_z_reg <= {W{1'b0}};
         drdy_mag <= 1'b0;
      end else begin
         if (mag_new) begin
            mag_x_reg <= res_x_reg;
            mag_y_reg <= res_y_reg;
            mag_z_reg <= res_z_reg;
         end
         if (mag_new) begin
            drdy_mag <= 1'b1;
         end else if (rd_mag_z) begin
            drdy_mag <= 1'b0;
         end
      end
   end
endmodule

// *** swc_front_model.sv ***
`timescale 1ns/1ns
// far side: trim store and magnetometer sensing front end
module swc_front_model #(
   parameter logic [7:0] TSENS = 8'h5a,
   parameter logic [7:0] TOFF = 8'h04,
   parameter logic signed [15:0] FX = 16'sh0123,
   parameter logic signed [15:0] BIAS = 16'sd655
) (
   // clock, reset, answer speed
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   // trim store
   input wire logic nvm_rd,
   input wire logic [7:0] nvm_addr,
   output logic [7:0] nvm_data,
   // magnetometer front end
   input wire logic mag_acq_start,
   input wire logic mag_strap_en,
   output logic mag_acq_valid,
   output logic signed [15:0] mag_raw_x,
   output logic signed [15:0] mag_raw_y,
   output logic signed [15:0] mag_raw_z
);
   int wait_cnt; // cycles left before a result
   // trim store answers while the read strobe stands; inverted data otherwise
   assign nvm_data = ((nvm_addr == 8'h00) ? TSENS : TOFF) ^ {8{~nvm_rd}};
   // strap adds bias on top of the field
   always @(posedge clk) begin
      mag_acq_valid <= 1'b0;
      if (!rst_n) begin
         wait_cnt <= 0;
         {mag_raw_x, mag_raw_y, mag_raw_z} <= '0;
      end else if (mag_acq_start) begin
         wait_cnt <= slow ? 9 : 1;
      end else if (wait_cnt == 1) begin
         wait_cnt <= 0;
         mag_acq_valid <= 1'b1;
         mag_raw_x <= FX + (mag_strap_en ? BIAS : 16'sd0);
         mag_raw_y <= FX + (mag_strap_en ? BIAS : 16'sd0);
         mag_raw_z <= FX + (mag_strap_en ? BIAS : 16'sd0);
      end else begin
         wait_cnt <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
         {mag_raw_x, mag_raw_y, mag_raw_z} <= ~{mag_raw_x, mag_raw_y, mag_raw_z}; // no valid data
      end
   end
endmodule

// *** swc_top_asserts.sv ***
`timescale 1ns/1ns
// pin-level checks of the control block
module swc_top_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // front end and status pins
   input wire logic mag_core_pwr,
   input wire logic mag_acq_start,
   input wire logic mag_set_pulse,
   input wire logic mag_strap_en,
   input wire logic acc_test_force,
   input wire logic acc_odr_high,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   int set_len; // a counter, as 20 is too long to repeat
   always @(posedge clk) begin
      if (!rst_n || !mag_set_pulse) begin
         set_len <= 0;
      end else begin
         set_len <= set_len + 1;
      end
   end
   sequence mode_wr;
      reg_wr && reg_addr == 8'h0a && reg_wdata == 8'h03;
   endsequence
   sequence mode_rd;
      reg_rd && reg_addr == 8'h0a;
   endsequence
   a_st_force_track: assert property (
      reg_wr && reg_addr == 8'h01 |-> ##3 acc_test_force == $past(reg_wdata[0], 3))
      else $error("self-test force does not follow its bit");
   a_set_width: assert property ($fell(mag_set_pulse) |-> set_len == 20)
      else $error("set pulse width wrong");
   a_acq_after_set: assert property (
      mag_acq_start && !mag_strap_en |-> $past(mag_set_pulse) || $past(mag_set_pulse, 2))
      else $error("first acquisition not after set pulse");
   a_strap_no_set: assert property (mag_strap_en |-> !mag_set_pulse)
      else $error("strap and set pulse together");
   a_strap_acq_start: assert property ($rose(mag_strap_en) |-> ##[0:1] mag_acq_start)
      else $error("bias acquisition not started");
   a_pwr_off_idle: assert property (
      !mag_core_pwr [*4] |=> !mag_acq_start && !mag_set_pulse && !mag_strap_en)
      else $error("measuring without core power");
   a_odr_drop_cause: assert property (
      $fell(acc_odr_high) |-> $past(reg_wr && reg_addr == 8'h00, 2))
      else $error("rate dropped without a control write");
   a_irq_masked: assert property (
      reg_wr && reg_addr == 8'h0c && reg_wdata == 8'h00 |-> ##3 !irq)
      else $error("interrupt high with all masked");
   a_mode_readback: assert property (mode_wr ##[1:2] mode_rd |=> reg_rdata == 8'h03)
      else $error("mode write lost");
endmodule
bind swc_top swc_top_asserts i_swc_top_asserts (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .mag_core_pwr, .mag_acq_start, .mag_set_pulse, .mag_strap_en, .acc_test_force, .acc_odr_high, .irq);

// *** tb_swc_top.sv ***
`timescale 1ns/1ns
// register-port scenarios checked at pins and readback
module tb_swc_top;
   localparam logic [7:0] TSENS = 8'h5a;
   localparam logic [7:0] TOFF = 8'h04;
   localparam logic signed [15:0] OFF = {{8{TOFF[7]}}, TOFF};
   localparam logic signed [15:0] BIG = 16'sd1000;
   localparam logic signed [15:0] FX = 16'sh0123;
   localparam logic signed [15:0] BIAS = 16'sd655;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, acc_sample_valid = 0, mag_core_pwr = 1, slow = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0;
   logic signed [15:0] acc_raw_x = 0, acc_raw_y = 0, acc_raw_z = 0;
   wire logic [7:0] reg_rdata, nvm_addr, nvm_data;
   wire logic nvm_rd, acc_test_force, acc_odr_high, mag_acq_start, mag_set_pulse, mag_strap_en, mag_acq_valid;
   wire logic signed [15:0] mag_raw_x, mag_raw_y, mag_raw_z;
   wire logic drdy_acc, drdy_mag, int1, int2, irq;
   int mismatches = 0, compares = 0, cycles = 0;
   always #25 clk = ~clk;
   swc_top i_swc_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nvm_rd, .nvm_addr,
      .nvm_data, .acc_sample_valid, .acc_raw_x, .acc_raw_y, .acc_raw_z, .acc_test_force, .acc_odr_high,
      .mag_core_pwr, .mag_acq_start, .mag_set_pulse, .mag_strap_en, .mag_acq_valid, .mag_raw_x, .mag_raw_y,
      .mag_raw_z, .drdy_acc, .drdy_mag, .int1, .int2, .irq);
   swc_front_model #(.TSENS(TSENS), .TOFF(TOFF), .FX(FX), .BIAS(BIAS)) i_swc_front_model (.clk, .rst_n, .slow,
      .nvm_rd, .nvm_addr, .nvm_data, .mag_acq_start, .mag_strap_en, .mag_acq_valid, .mag_raw_x, .mag_raw_y,
      .mag_raw_z);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e);
      rd(a, e[7:0]);
      rd(a + 8'h01, e[15:8]);
   endtask
   // one acceleration sample; lines change once it is taken
   task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
      @(posedge clk);
      {acc_sample_valid, acc_raw_x, acc_raw_y, acc_raw_z} <= {1'b1, x, y, z};
      @(posedge clk);
      {acc_sample_valid, acc_raw_x, acc_raw_y, acc_raw_z} <= {1'b0, ~x, ~y, ~z};
      @(posedge clk);
      #1;
   endtask
   task automatic wdr;
      repeat (300) if (!drdy_mag) @(posedge clk);
      #1;
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         conclude;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd16(8'h1e, {TOFF, TSENS});
      rd(8'h0b, 8'h20);
      rd(8'hff, 8'h00);
      wr(8'h01, 8'h01);
      repeat (3) @(posedge clk);
      #1 chk(acc_test_force, 1);
      smp(BIG, 0, 0);
      chk(drdy_acc, 1);
      rd16(8'h10, BIG - OFF);
      wr(8'h01, 8'h10);
      repeat (3) @(posedge clk);
      #1 chk(acc_test_force, 0);
      smp(BIG, 0, 0);
      rd16(8'h10, (BIG - OFF) >>> 1);
      rd16(8'h14, (16'sd0 - OFF) >>> 1);
      @(posedge clk);
      #1 chk(drdy_acc, 0);
      // wakeup on x for one output, free-fall on y and z for the other
      wr(8'h02, 8'h01);
      wr(8'h03, 8'h01);
      wr(8'h05, 8'h0e);
      wr(8'h06, 8'h01);
      wr(8'h0b, 8'hff);
      wr(8'h0c, 8'h04);
      smp(BIG, 0, 0);
      @(posedge clk);
      #1 chk({int1, int2, irq}, 3'b111);
      rd(8'h0b, 8'h0d);
      wr(8'h0b, 8'h04);
      repeat (3) @(posedge clk);
      #1 chk(irq, 0);
      wr(8'h00, 8'h01);
      smp(0, BIG, BIG);
      smp(BIG, 0, 0);
      @(posedge clk);
      #1 chk({int1, acc_odr_high}, 2'b10);
      wr(8'h00, 8'h03);
      smp(0, BIG, BIG);
      smp(BIG, 0, 0);
      repeat (3) @(posedge clk);
      #1 chk(acc_odr_high, 1);
      rd(8'h0b, 8'h1d);
      wr(8'h00, 8'h00);
      wr(8'h08, 8'h01);
      wr(8'h0a, 8'h01);
      wdr;
      chk(drdy_mag, 1);
      rd16(8'h18, BIAS);
      rd16(8'h1c, BIAS);
      @(posedge clk);
      #1 chk(drdy_mag, 0);
      rd(8'h0a, 8'h03);
      slow <= 1'b1;
      wr(8'h08, 8'h00);
      wr(8'h0a, 8'h01);
      wdr;
      rd16(8'h18, FX);
      rd16(8'h1c, FX);
      wr(8'h0a, 8'h00);
      wdr;
      rd16(8'h1c, FX);
      rd(8'h0a, 8'h00);
      wr(8'h0a, 8'h03);
      rd(8'h0a, 8'h03);
      wdr;
      @(posedge clk);
      mag_core_pwr <= 1'b0;
      repeat (4) @(posedge clk);
      wr(8'h0a, 8'h01);
      repeat (60) @(posedge clk);
      rd(8'h0a, 8'h01);
      wr(8'h09, 8'ha0);
      rd(8'h09, 8'ha0);
      wr(8'h0c, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk(irq, 0);
      conclude;
   end
endmodule
